/* bus_dram_pkg.sv */
package bus_dram_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int MUX_W = 7;
  localparam int COL_W = 9;
  localparam int BANKS = 4;
  localparam int ROM_SEL_LSB = 13;
  localparam int ROM_SEL_W = 3;
  localparam int ROM_ADDR_W = 13;
  localparam int REG_SEL_W = 7;
  localparam int REG_COUNT = 128;
  localparam logic [7:0] LOW_ADDR_RST = 8'h00;
  localparam logic [7:0] IO_SPACE_TOP = 8'hFF;
  // cycle codes as {memory-or-io, status_bit_hi, status_bit_lo}
  localparam logic [2:0] CODE_FETCH = 3'h3;
  localparam logic [2:0] CODE_MEM_RD = 3'h2;
  localparam logic [2:0] CODE_MEM_WR = 3'h1;
  localparam logic [2:0] CODE_IO_RD = 3'h6;
  localparam logic [2:0] CODE_IO_WR = 3'h5;
  localparam logic [2:0] CODE_INTR_ACK_STROBE_N = 3'h7;
  // dram sequencer timing in ns, rounded up to whole clocks
  localparam int ROW_HOLD_NS = 8;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ROW_HOLD_CYC = (ROW_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int COL_HOLD_NS = 12;
  localparam int COL_HOLD_CYC = (COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    CYC_NONE  = 3'b000,
    CYC_FETCH = 3'b001,
    CYC_MRD   = 3'b011,
    CYC_MWR   = 3'b010,
    CYC_IORD  = 3'b110,
    CYC_IOWR  = 3'b111,
    CYC_INTR_ACK_STROBE_N  = 3'b101,
    CYC_HALT  = 3'b100
  } cycle_e;

  typedef enum logic [1:0] {
    DR_IDLE = 2'b00,
    DR_ROW  = 2'b01,
    DR_COL  = 2'b11,
    DR_DONE = 2'b10
  } dram_state_e;
endpackage : bus_dram_pkg

/* cycle_decoder.sv */
`timescale 1ns/1ps
module cycle_decoder
  import bus_dram_pkg::*;
(
  // status
  input  wire logic                 io_mem_in,
  input  wire logic                 status_bit_hi_in,
  input  wire logic                 status_bit_lo_in,
  input  wire logic                 read_strobe_n_in,
  input  wire logic                 write_strobe_n_in,
  input  wire logic                 intr_ack_strobe_n_in,
  // result
  output bus_dram_pkg::cycle_e      cycle_out,
  output logic                      idle_out
);
  import bus_dram_pkg::*;
  logic [2:0] code;

  always_comb begin
    code     = {io_mem_in, status_bit_hi_in, status_bit_lo_in};
    idle_out = read_strobe_n_in & write_strobe_n_in & intr_ack_strobe_n_in;  // RL6
    cycle_out = CYC_NONE;
    if ({status_bit_hi_in, status_bit_lo_in} == 2'b00) begin
      cycle_out = CYC_HALT;  // RL7
    end else if (!idle_out) begin
      unique case (code)  // RL4 RL5
        CODE_FETCH:  cycle_out = read_strobe_n_in ? CYC_NONE : CYC_FETCH;
        CODE_MEM_RD: cycle_out = read_strobe_n_in ? CYC_NONE : CYC_MRD;
        CODE_MEM_WR: cycle_out = write_strobe_n_in ? CYC_NONE : CYC_MWR;
        CODE_IO_RD:  cycle_out = read_strobe_n_in ? CYC_NONE : CYC_IORD;
        CODE_IO_WR:  cycle_out = write_strobe_n_in ? CYC_NONE : CYC_IOWR;
        CODE_INTR_ACK_STROBE_N:   cycle_out = intr_ack_strobe_n_in ? CYC_NONE : CYC_INTR_ACK_STROBE_N;
        default:     cycle_out = CYC_NONE;
      endcase
    end
  end
endmodule : cycle_decoder

/* addr_decoder.sv */
`timescale 1ns/1ps
module addr_decoder
  import bus_dram_pkg::*;
(
  // address and qualifiers
  input  wire logic [15:0]          addr_in,
  input  wire logic                 mem_rd_in,
  input  wire logic                 io_wr_in,
  // selects
  output logic [7:0]                rom_select_enable_out,
  output logic [12:0]               rom_addr_out,
  output logic [127:0]              reg_load_out
);
  import bus_dram_pkg::*;

  function automatic logic [127:0] one_hot7(input logic [6:0] idx);
    one_hot7 = 128'(1) << idx;
  endfunction : one_hot7

  always_comb begin
    rom_select_enable_out = '0;
    if (mem_rd_in) begin
      rom_select_enable_out = 8'(8'h01 << addr_in[15:13]);  // RL9
    end
    rom_addr_out = addr_in[12:0];  // RL9
    reg_load_out = io_wr_in ? one_hot7(addr_in[6:0]) : '0;  // RL10
  end
endmodule : addr_decoder

/* cpu_bus_dram_address_mux.sv */
`timescale 1ns/1ps
// Function
// [RL1] cpu muxes low address onto data lines
// [RL2] latch low address byte from bus
// [RL3] bus cycles last three to six states
// [RL4] classify cycle from three status lines
// [RL5] decode fetch, read, write, io, ack codes
// [RL6] idle cycles transfer nothing
// [RL7] halt starts no access
// [RL8] io space 256 locations by io line
// [RL9] top three bits select rom, rest address
// [RL10] low seven bits pick register load
// [RL11] row address from seven low inputs
// [RL12] strap selects 4k or 16k mode
// [RL13] high inputs form column, top chip select
// [RL14] seven outputs drive dram address
// [RL15] write enable during write accesses
// [RL16] column strobe latches column address
// [RL17] one row strobe per selected bank
// [RL18] requester drives read/write requests low
// [RL19] system ack at start, delayed by refresh
// [RL20] transfer ack marks valid data
// [RL21] row strobe before column strobe
// [RL22] reset clears strobes and latched byte
module cpu_bus_dram_address_mux
  import bus_dram_pkg::*;
(
  // clock and reset
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_n_in,
  // processor bus
  input  wire logic [7:0]           addr_data_in,
  input  wire logic [7:0]           addr_hi_in,
  input  wire logic                 addr_latch_en_in,
  input  wire logic                 io_mem_in,
  input  wire logic                 status_bit_hi_in,
  input  wire logic                 status_bit_lo_in,
  input  wire logic                 read_strobe_n_in,
  input  wire logic                 write_strobe_n_in,
  input  wire logic                 intr_ack_strobe_n_in,
  // decoded cycle
  output bus_dram_pkg::cycle_e      cycle_out,
  output logic                      idle_out,
  output logic [7:0]                low_addr_out,
  output logic                      io_space_out,
  // rom and register selects
  output logic [7:0]                rom_select_enable_out,
  output logic [12:0]               rom_addr_out,
  output logic [127:0]              reg_load_out,
  // dram requester side
  input  wire logic                 read_req_n_in,
  input  wire logic                 write_req_n_in,
  input  wire logic                 guarded_chip_select_n_in,
  input  wire logic                 refresh_busy_in,
  input  wire logic                 size_strap_4k_in,
  input  wire logic [6:0]           row_addr_in,
  input  wire logic [8:0]           col_addr_in,
  input  wire logic [1:0]           bank_sel_in,
  // dram array
  output logic [6:0]                dram_addr_out,
  output logic [3:0]                row_strobe_n_out,
  output logic                      col_strobe_n_out,
  output logic                      write_enable_n_out,
  output logic                      system_ack_out,
  output logic                      transfer_ack_out
);
  import bus_dram_pkg::*;

  cycle_e      cyc;
  logic        idle;
  logic [7:0]  low_addr;
  logic        access_ok;
  dram_state_e state;
  logic [1:0]  cnt;
  logic        is_write;
  logic [1:0]  bank;
  logic [6:0]  row_q;
  logic [8:0]  col_q;
  logic        system_ack_owed;
  logic        chip_sel_4k;
  logic        req;

  cycle_decoder u_cyc (
    .io_mem_in            (io_mem_in),
    .status_bit_hi_in     (status_bit_hi_in),
    .status_bit_lo_in     (status_bit_lo_in),
    .read_strobe_n_in     (read_strobe_n_in),
    .write_strobe_n_in    (write_strobe_n_in),
    .intr_ack_strobe_n_in (intr_ack_strobe_n_in),
    .cycle_out            (cyc),
    .idle_out             (idle)
  );

  // halt and idle leave access_ok low so no access starts
  assign access_ok = (cyc != CYC_NONE) && (cyc != CYC_HALT) && !idle;  // RL6 RL7

  addr_decoder u_addr (
    .addr_in               ({addr_hi_in, low_addr}),
    .mem_rd_in             (access_ok && (cyc == CYC_MRD || cyc == CYC_FETCH)),
    .io_wr_in              (access_ok && cyc == CYC_IOWR),
    .rom_select_enable_out (rom_select_enable_out),
    .rom_addr_out          (rom_addr_out),
    .reg_load_out          (reg_load_out)
  );

  // the bus turns to data after the latch strobe, so hold the byte here
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      low_addr <= LOW_ADDR_RST;  // RL22
    end else if (addr_latch_en_in) begin
      low_addr <= addr_data_in;  // RL2 RL1
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      cycle_out    <= CYC_NONE;
      idle_out     <= 1'b0;
      io_space_out <= 1'b0;
    end else begin
      cycle_out    <= cyc;
      idle_out     <= idle;
      io_space_out <= access_ok && io_mem_in;  // RL8
    end
  end

  assign low_addr_out = low_addr;
  assign req = !guarded_chip_select_n_in && (!read_req_n_in || !write_req_n_in);  // RL18

  // sequencer: row strobe, then column, then done
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      state <= DR_IDLE;
      cnt   <= '0;
    end else begin
      unique case (state)
        DR_IDLE: begin
          if (req && !refresh_busy_in) begin
            state <= DR_ROW;
            cnt   <= 2'(ROW_HOLD_CYC - 1);
          end
        end
        DR_ROW: begin
          if (cnt == '0) begin
            state <= DR_COL;  // RL21
            cnt   <= 2'(COL_HOLD_CYC - 1);
          end else begin
            cnt <= cnt - 2'd1;
          end
        end
        DR_COL: begin
          if (cnt == '0) begin
            state <= DR_DONE;
          end else begin
            cnt <= cnt - 2'd1;
          end
        end
        DR_DONE: state <= DR_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      is_write <= 1'b0;
      bank     <= '0;
      row_q    <= '0;
      col_q    <= '0;
    end else if (state == DR_IDLE && req && !refresh_busy_in) begin
      is_write <= !write_req_n_in;
      bank     <= bank_sel_in;
      row_q    <= row_addr_in;  // RL11
      col_q    <= col_addr_in;
    end
  end

  // in 4k mode the top column bit is a chip select, not an address
  assign chip_sel_4k = col_q[COL_W-1];  // RL12 RL13

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      dram_addr_out <= '0;
    end else if (state == DR_IDLE) begin
      // show the incoming row a cycle early so it is settled before the row strobe falls
      dram_addr_out <= size_strap_4k_in ? {col_addr_in[COL_W-1], row_addr_in[5:0]} : row_addr_in;  // RL21 RL11
    end else if (state == DR_COL || (state == DR_ROW && cnt == '0)) begin
      dram_addr_out <= size_strap_4k_in ? {chip_sel_4k, col_q[5:0]} : col_q[6:0];  // RL13 RL14
    end else begin
      dram_addr_out <= size_strap_4k_in ? {chip_sel_4k, row_q[5:0]} : row_q;  // RL14
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      row_strobe_n_out   <= '1;  // RL22
      col_strobe_n_out   <= 1'b1;
      write_enable_n_out <= 1'b1;
    end else begin
      for (int b = 0; b < BANKS; b++) begin
        row_strobe_n_out[b] <= !((state == DR_ROW || state == DR_COL) && bank == 2'(b));  // RL17
      end
      col_strobe_n_out   <= !(state == DR_COL);  // RL16 RL21
      write_enable_n_out <= !(is_write && (state == DR_ROW || state == DR_COL));  // RL15
    end
  end

  // ack is owed if a request waited on refresh; then it comes with transfer ack
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      system_ack_owed        <= 1'b0;
      system_ack_out   <= 1'b0;
      transfer_ack_out <= 1'b0;
    end else begin
      if (state == DR_IDLE && req && refresh_busy_in) begin
        system_ack_owed <= 1'b1;
      end else if (state == DR_DONE) begin
        system_ack_owed <= 1'b0;
      end
      system_ack_out   <= (state == DR_IDLE && req && !refresh_busy_in && !system_ack_owed)
                          || (state == DR_COL && cnt == '0 && system_ack_owed);  // RL19
      transfer_ack_out <= (state == DR_COL && cnt == '0);  // RL20
    end
  end

  sequence row_then_col_s;
    (state == DR_ROW) ##1 (state == DR_ROW || state == DR_COL);
  endsequence

  row_first_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)  // RL21
    $fell(col_strobe_n_out) |-> row_strobe_n_out != 4'hF)
    else $error("column strobe without row strobe");
  one_bank_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)  // RL17
    $countones(~row_strobe_n_out) <= 1)
    else $error("more than one row strobe");
  bank_match_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)  // RL17
    (row_strobe_n_out != 4'hF) |-> !row_strobe_n_out[bank])
    else $error("wrong bank strobed");
  col_seq_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)  // RL16
    row_then_col_s |-> ##[1:4] !col_strobe_n_out)
    else $error("column strobe missing");
  transfer_ack_col_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)  // RL20
    transfer_ack_out |-> $past(state == DR_COL))
    else $error("transfer ack outside column phase");
  we_write_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)  // RL15
    !write_enable_n_out |-> is_write)
    else $error("write enable on a read");
  halt_quiet_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)  // RL7
    (cyc == CYC_HALT) |-> (reg_load_out == '0 && rom_select_enable_out == '0))
    else $error("access during halt");
  addr_latch_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)  // RL2
    addr_latch_en_in |=> low_addr_out == $past(addr_data_in))
    else $error("low address not latched");
endmodule : cpu_bus_dram_address_mux

/* dram_array_model.sv */
`timescale 1ns/1ps
module dram_array_model (
  // array pins
  input  wire logic [6:0] dram_addr_in,
  input  wire logic [3:0] row_strobe_n_in,
  input  wire logic       col_strobe_n_in,
  input  wire logic       write_enable_n_in,
  // captured access
  output logic [6:0]      row_out,
  output logic [6:0]      col_out,
  output logic [3:0]      bank_out,
  output logic            wrote_out,
  output logic            order_bad_out
);
  logic any_row;
  assign any_row = ~&row_strobe_n_in;
  initial begin
    order_bad_out = 1'b0;
    wrote_out = 1'b0;
  end
  // the array latches whatever the pins show at the falling strobe
  always @(posedge any_row) begin
    row_out = dram_addr_in;
    bank_out = ~row_strobe_n_in;
  end
  // a column strobe with no open row would be lost by a real array
  always @(negedge col_strobe_n_in) begin
    col_out = dram_addr_in;
    wrote_out = ~write_enable_n_in;
    if (!any_row) order_bad_out = 1'b1;
  end
endmodule : dram_array_model

/* cpu_bus_dram_address_mux_tb.sv */
`timescale 1ns/1ps
module cpu_bus_dram_address_mux_tb;
  import bus_dram_pkg::*;
  logic core_clk_in = 0, rst_n_in = 0, addr_latch_en_in = 0, io_mem_in = 0, status_bit_hi_in = 0;
  logic status_bit_lo_in = 0, read_strobe_n_in = 1, write_strobe_n_in = 1, intr_ack_strobe_n_in = 1;
  logic read_req_n_in = 1, write_req_n_in = 1, guarded_chip_select_n_in = 1, refresh_busy_in = 0;
  logic size_strap_4k_in = 0;
  logic [7:0] addr_data_in = 0, addr_hi_in = 0, low_addr_out, rom_select_enable_out;
  logic [6:0] row_addr_in = 0, dram_addr_out, row_q, col_q;
  logic [8:0] col_addr_in = 0;
  logic [1:0] bank_sel_in = 0;
  logic [3:0] row_strobe_n_out, bank_q;
  logic [12:0] rom_addr_out;
  logic [127:0] reg_load_out;
  logic idle_out, io_space_out, col_strobe_n_out, write_enable_n_out, system_ack_out, transfer_ack_out;
  logic wrote_q, order_bad;
  cycle_e cycle_out;
  int num_errors = 0, n_checks = 0;

  cpu_bus_dram_address_mux uut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .addr_data_in(addr_data_in),
    .addr_hi_in(addr_hi_in), .addr_latch_en_in(addr_latch_en_in), .io_mem_in(io_mem_in),
    .status_bit_hi_in(status_bit_hi_in), .status_bit_lo_in(status_bit_lo_in), .read_strobe_n_in(read_strobe_n_in),
    .write_strobe_n_in(write_strobe_n_in), .intr_ack_strobe_n_in(intr_ack_strobe_n_in), .cycle_out(cycle_out),
    .idle_out(idle_out), .low_addr_out(low_addr_out), .io_space_out(io_space_out),
    .rom_select_enable_out(rom_select_enable_out), .rom_addr_out(rom_addr_out), .reg_load_out(reg_load_out),
    .read_req_n_in(read_req_n_in), .write_req_n_in(write_req_n_in),
    .guarded_chip_select_n_in(guarded_chip_select_n_in), .refresh_busy_in(refresh_busy_in),
    .size_strap_4k_in(size_strap_4k_in), .row_addr_in(row_addr_in), .col_addr_in(col_addr_in),
    .bank_sel_in(bank_sel_in), .dram_addr_out(dram_addr_out), .row_strobe_n_out(row_strobe_n_out),
    .col_strobe_n_out(col_strobe_n_out), .write_enable_n_out(write_enable_n_out),
    .system_ack_out(system_ack_out), .transfer_ack_out(transfer_ack_out));
  dram_array_model array (.dram_addr_in(dram_addr_out), .row_strobe_n_in(row_strobe_n_out),
    .col_strobe_n_in(col_strobe_n_out), .write_enable_n_in(write_enable_n_out), .row_out(row_q),
    .col_out(col_q), .bank_out(bank_q), .wrote_out(wrote_q), .order_bad_out(order_bad));

  always #2 core_clk_in = ~core_clk_in;

  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // one machine cycle: address phase with latch enable, then data phase with strobes
  task automatic bus_cycle(input logic [5:0] pins, input cycle_e exp, input logic [7:0] lo, input logic [7:0] hi);
    bit mrd;
    mrd = (exp == CYC_FETCH) || (exp == CYC_MRD);
    @(negedge core_clk_in);
    {io_mem_in, status_bit_hi_in, status_bit_lo_in} = pins[5:3];
    addr_data_in = lo;
    addr_hi_in = hi;
    addr_latch_en_in = 1;
    @(negedge core_clk_in);
    addr_latch_en_in = 0;
    addr_data_in = ~lo;
    {read_strobe_n_in, write_strobe_n_in, intr_ack_strobe_n_in} = pins[2:0];
    @(negedge core_clk_in);
    chk(cycle_out === exp, "cycle code");
    chk(low_addr_out === lo, "low byte lost");
    chk(rom_select_enable_out === (mrd ? 8'h01 << hi[7:5] : 8'h00), "rom select");
    if (mrd) chk(rom_addr_out === {hi[4:0], lo}, "rom address");
    chk(reg_load_out === (exp == CYC_IOWR ? 128'h1 << lo[6:0] : 128'h0), "register load");
    if (exp inside {CYC_IORD, CYC_IOWR, CYC_MRD, CYC_MWR}) chk(io_space_out === pins[5], "io space");
    if (exp == CYC_NONE) chk(idle_out === 1'b1, "idle");
    {read_strobe_n_in, write_strobe_n_in, intr_ack_strobe_n_in} = 3'b111;
  endtask : bus_cycle

  // request taken at the first edge refresh allows; acks counted on falling edges
  task automatic dram_access(input logic wr, input logic strap, input logic [1:0] bank, input int rfsh);
    int t_system_ack, t_transfer_ack, i;
    t_system_ack = -1;
    t_transfer_ack = -1;
    @(negedge core_clk_in);
    size_strap_4k_in = strap;
    row_addr_in = 7'h55 ^ {5'h00, bank};
    col_addr_in = 9'h1A3 ^ {7'h00, bank};
    bank_sel_in = bank;
    refresh_busy_in = (rfsh > 0);
    guarded_chip_select_n_in = 0;
    read_req_n_in = wr;
    write_req_n_in = ~wr;
    for (i = 1; i < 20; i++) begin
      @(negedge core_clk_in);
      if (system_ack_out === 1'b1 && t_system_ack < 0) t_system_ack = i;
      if (transfer_ack_out === 1'b1 && t_transfer_ack < 0) t_transfer_ack = i;
      if (i <= rfsh) chk(system_ack_out === 1'b0 && row_strobe_n_out === 4'hF, "access during refresh");
      if (i == rfsh) refresh_busy_in = 0;
      if (t_system_ack > 0) {read_req_n_in, write_req_n_in, guarded_chip_select_n_in} = 3'b111;
    end
    if (rfsh == 0) chk(t_system_ack == 1 && t_transfer_ack == 6, "ack timing");
    else chk(t_system_ack == t_transfer_ack && t_transfer_ack == rfsh + 6, "deferred acks");
    chk(row_q === row_addr_in && bank_q === 4'h1 << bank, "row or bank");
    if (strap) chk(col_q === {col_addr_in[8], col_addr_in[5:0]}, "column 4k");
    else chk(col_q === col_addr_in[6:0], "column 16k");
    chk(wrote_q === wr && order_bad === 1'b0, "write enable or order");
    chk(row_strobe_n_out === 4'hF && col_strobe_n_out && write_enable_n_out, "strobes left low");
  endtask : dram_access

  initial begin
    repeat (2) @(negedge core_clk_in);
    chk(row_strobe_n_out === 4'hF && col_strobe_n_out === 1'b1 && low_addr_out === 8'h00, "reset");
    rst_n_in = 1;
    bus_cycle(6'b011011, CYC_FETCH, 8'h40, 8'h05);
    bus_cycle(6'b010011, CYC_MRD, 8'h41, 8'hA5);
    bus_cycle(6'b001101, CYC_MWR, 8'h42, 8'hE5);
    bus_cycle(6'b110011, CYC_IORD, 8'hFF, 8'h00);
    bus_cycle(6'b101101, CYC_IOWR, 8'h7F, 8'h00);
    bus_cycle(6'b111110, CYC_INTR_ACK_STROBE_N, 8'h44, 8'h25);
    bus_cycle(6'b010111, CYC_NONE, 8'h45, 8'h65);
    bus_cycle(6'b000111, CYC_HALT, 8'h46, 8'h85);
    for (int b = 0; b < 4; b++) dram_access(b[0], b[1], b[1:0], 0);
    dram_access(1'b0, 1'b0, 2'd2, 4);
    print_verdict();
  end

  initial begin
    repeat (3000) @(posedge core_clk_in);
    num_errors++;
    print_verdict();
  end
endmodule : cpu_bus_dram_address_mux_tb
